// file: hw/slc_pkg.sv
// shared constants and types for the speaker and line-output control block
package slc_pkg;
	localparam int CLK_HZ = 10_000_000;
	localparam int RAMP_MS = 300;
	localparam logic [21:0] RAMP_CYCLES = 22'(RAMP_MS * (CLK_HZ / 1000));
	localparam logic [10:0] REC_PERIOD_FAST = 11'h200;
	localparam logic [10:0] REC_PERIOD_SLOW = 11'h400;
	localparam logic [5:0] GAIN_MIN = 6'h00;
	localparam logic [5:0] GAIN_FIX = 6'h09;
	localparam logic [5:0] GAIN_START = 6'h0c;
	localparam logic [5:0] LIM_STEP = 6'h01;
	localparam logic [6:0] REC_STEP = 7'h02;
	localparam logic [5:0] CEIL_RST = 6'h10;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_CEIL = 4'h4;
	localparam logic [3:0] OFS_STAT = 4'h8;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int SYN_FS = 0;
	localparam int SYN_ABOVE = 1;
	localparam int SYN_BELOW = 2;
	localparam int SYN_ZERO = 3;

	typedef enum logic [2:0] {LO_OFF, LO_RAMPUP, LO_SAVE, LO_ACTIVE, LO_RAMPDN} slc_lo_type;

	typedef struct packed {
		logic       recSel;
		logic       alcEn;
		logic [1:0] gainSel;
		logic       spkEn;
		logic       spkPower;
		logic       loSave;
		logic       loPower;
	} slc_ctrl_type;

	typedef struct packed {
		logic       mixerHiZ;
		logic       spkPosHiZ;
		logic       spkNegHiZ;
		logic       spkNegMid;
		logic       ampOn;
		logic       loEnable;
		logic       loSaveMode;
		logic       loRampUp;
		logic       loRampDown;
		logic       loPulldown;
	} slc_out_type;

	typedef struct packed {
		logic         awRdy;
		logic         wRdy;
		logic         awHave;
		logic         wHave;
		logic [3:0]   awAddr;
		logic [7:0]   wData;
		logic         wStrb0;
		logic         bValid;
		logic [1:0]   bResp;
		logic         arRdy;
		logic         rValid;
		logic [31:0]  rData;
		logic [1:0]   rResp;
		slc_ctrl_type ctrl;
		logic [5:0]   ceil;
		logic [3:0]   synA;
		logic [3:0]   synB;
		logic [3:0]   synC;
		logic [3:0]   filt;
		slc_lo_type   lo;
		logic [21:0]  rampCnt;
		logic         initBusy;
		logic [10:0]  initCnt;
		logic [5:0]   gain;
		logic         limPhase;
		logic [10:0]  recCnt;
		logic         recArmed;
		slc_out_type  out;
	} slc_state_type;
endpackage

// file: hw/slc_speaker_lineout_ctrl.sv
// speaker level control, speaker power states and line-output pop-reduction sequencing
// Contract
// - save bit forces line output into power-save first
// - power-up in save ramps output to common voltage
// - power-down in save ramps output to ground
// - two-bit select sets speaker amplifier gain
// - speaker power zero: all speaker pins high-impedance
// - power on, output disabled: amplifier power-save
// - level control runs only when enabled
// - limiter drops one step every two samples
// - recovery raises two steps at zero crossing
// - recovery never exceeds programmed gain ceiling
// - hold band keeps gain unchanged
// - speaker power-up runs fixed-gain initialization cycle
// - disabled level control fixes gain at code
`timescale 1ns/100ps
module slc_speaker_lineout_ctrl
	import slc_pkg::*;
#(
	parameter logic [21:0] RAMP_LEN = RAMP_CYCLES
) (
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [31:0] s_axi_araddr,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	input  wire logic        fsClk,
	input  wire logic        levelAbove,
	input  wire logic        levelBelow,
	input  wire logic        zeroCross,
	output logic [1:0]       speakerGainSel,
	output logic [5:0]       levelGain,
	output slc_out_type      pinCtrl
);
	slc_state_type st;
	slc_state_type next_st;
	slc_state_type stRst;
	logic          fsTick;
	logic          zeroTick;
	logic          run;
	logic [10:0]   recPeriod;
	logic [6:0]    gainUp;

	always_comb begin
		stRst = '0;
		stRst.lo = LO_OFF;
		stRst.ctrl = CTRL_RST;
		stRst.ceil = CEIL_RST;
		stRst.gain = GAIN_FIX;
		stRst.out = 10'h000;
		stRst.out.mixerHiZ = 1'b1;
		stRst.out.spkPosHiZ = 1'b1;
		stRst.out.spkNegHiZ = 1'b1;
		stRst.out.loPulldown = 1'b1;
	end

	always_comb begin
		next_st = st;
		fsTick = 1'b0;
		zeroTick = 1'b0;
		// pins and fs come from outside: three stages, accept once stages two and three agree
		next_st.synA = {zeroCross, levelBelow, levelAbove, fsClk};
		next_st.synB = st.synA;
		next_st.synC = st.synB;
		for (int i = 0; i < 4; i++) begin
			if (st.synB[i] == st.synC[i]) begin
				next_st.filt[i] = st.synB[i];
			end
		end
		fsTick = next_st.filt[SYN_FS] && !st.filt[SYN_FS];
		zeroTick = next_st.filt[SYN_ZERO] && !st.filt[SYN_ZERO];

		// write channel: address and data may arrive in either order
		if (st.bValid && s_axi_bready) begin
			next_st.bValid = 1'b0;
		end
		if (s_axi_awvalid && st.awRdy) begin
			next_st.awHave = 1'b1;
			next_st.awAddr = s_axi_awaddr[3:0];
		end
		if (s_axi_wvalid && st.wRdy) begin
			next_st.wHave = 1'b1;
			next_st.wData = s_axi_wdata[7:0];
			next_st.wStrb0 = s_axi_wstrb[0];
		end
		if (st.awHave && st.wHave && !st.bValid) begin
			next_st.awHave = 1'b0;
			next_st.wHave = 1'b0;
			next_st.bValid = 1'b1;
			next_st.bResp = RESP_OKAY;
			case (st.awAddr)
				OFS_CTRL: begin
					if (st.wStrb0) begin
						next_st.ctrl = st.wData;
					end
				end
				OFS_CEIL: begin
					// period select and ceiling are taken as written; host keeps them static while powered
					if (st.wStrb0) begin
						next_st.ceil = st.wData[5:0];
					end
				end
				OFS_STAT: next_st.bResp = RESP_OKAY;
				default: next_st.bResp = RESP_SLVERR;
			endcase
		end
		next_st.awRdy = !next_st.awHave && !next_st.bValid;
		next_st.wRdy = !next_st.wHave && !next_st.bValid;

		// read channel
		if (st.rValid && s_axi_rready) begin
			next_st.rValid = 1'b0;
		end
		if (s_axi_arvalid && st.arRdy) begin
			next_st.rValid = 1'b1;
			next_st.rResp = RESP_OKAY;
			case (s_axi_araddr[3:0])
				OFS_CTRL: next_st.rData = {24'h000000, st.ctrl};
				OFS_CEIL: next_st.rData = {26'h0000000, st.ceil};
				OFS_STAT: next_st.rData = {20'h00000, 1'b0, st.lo, 1'b0, st.initBusy, st.gain};
				default: begin
					next_st.rData = 32'h00000000;
					next_st.rResp = RESP_SLVERR;
				end
			endcase
		end
		next_st.arRdy = !next_st.rValid;

		// line output sequencing
		case (st.lo)
			LO_OFF: begin
				next_st.rampCnt = 22'h000000;
				if (st.ctrl.loPower) begin
					next_st.lo = st.ctrl.loSave ? LO_RAMPUP : LO_ACTIVE;
				end
			end
			LO_RAMPUP: begin
				next_st.rampCnt = st.rampCnt + 22'h000001;
				if (!st.ctrl.loPower) begin
					next_st.lo = st.ctrl.loSave ? LO_RAMPDN : LO_OFF;
					next_st.rampCnt = 22'h000000;
				end else if (st.rampCnt == RAMP_LEN - 22'h000001) begin
					next_st.lo = LO_SAVE;
				end
			end
			LO_SAVE: begin
				next_st.rampCnt = 22'h000000;
				if (!st.ctrl.loPower) begin
					next_st.lo = LO_RAMPDN;
				end else if (!st.ctrl.loSave) begin
					next_st.lo = LO_ACTIVE;
				end
			end
			LO_ACTIVE: begin
				// save is checked ahead of power so a power change with the save bit set never skips the save state
				if (st.ctrl.loSave) begin
					next_st.lo = LO_SAVE;
				end else if (!st.ctrl.loPower) begin
					next_st.lo = LO_OFF;
				end
			end
			LO_RAMPDN: begin
				next_st.rampCnt = st.rampCnt + 22'h000001;
				if (st.ctrl.loPower) begin
					next_st.lo = LO_RAMPUP;
					next_st.rampCnt = 22'h000000;
				end else if (st.rampCnt == RAMP_LEN - 22'h000001) begin
					next_st.lo = LO_OFF;
				end
			end
			default: next_st.lo = LO_OFF;
		endcase

		// speaker initialization after power rises
		recPeriod = st.ctrl.recSel ? REC_PERIOD_SLOW : REC_PERIOD_FAST;
		run = st.ctrl.spkPower && st.ctrl.alcEn && !st.initBusy;
		gainUp = {1'b0, st.gain} + REC_STEP;
		if (!st.ctrl.spkPower) begin
			next_st.initBusy = 1'b0;
			next_st.gain = GAIN_FIX;
		end else if (st.initBusy) begin
			next_st.gain = GAIN_FIX;
			if (fsTick) begin
				next_st.initCnt = st.initCnt + 11'h001;
				if (st.initCnt == recPeriod - 11'h001) begin
					next_st.initBusy = 1'b0;
					next_st.gain = st.ctrl.alcEn ? GAIN_START : GAIN_FIX;
				end
			end
		end else if (!st.ctrl.alcEn) begin
			next_st.gain = GAIN_FIX;
		end
		if (!run || !st.filt[SYN_BELOW] || st.filt[SYN_ABOVE]) begin
			next_st.recCnt = 11'h000;
			next_st.recArmed = 1'b0;
		end
		if (!run || !st.filt[SYN_ABOVE]) begin
			next_st.limPhase = 1'b0;
		end
		if (run && st.filt[SYN_ABOVE]) begin
			if (fsTick) begin
				next_st.limPhase = !st.limPhase;
				if (st.limPhase && st.gain != GAIN_MIN) begin
					next_st.gain = st.gain - LIM_STEP;
				end
			end
		end else if (run && st.filt[SYN_BELOW]) begin
			// armed recovery waits for a zero crossing, but a full period more acts as timeout
			if (fsTick) begin
				next_st.recCnt = st.recCnt + 11'h001;
				if (st.recCnt == recPeriod - 11'h001) begin
					next_st.recCnt = 11'h000;
					next_st.recArmed = 1'b1;
				end
			end
			if (st.recArmed && (zeroTick || (fsTick && st.recCnt == recPeriod - 11'h001))) begin
				next_st.recArmed = 1'b0;
				next_st.recCnt = 11'h000;
				if (st.gain < st.ceil) begin
					next_st.gain = (gainUp > {1'b0, st.ceil}) ? st.ceil : gainUp[5:0];
				end
			end
		end
		// between the two thresholds neither branch fires: gain holds
		if (next_st.ctrl.spkPower && !st.ctrl.spkPower) begin
			next_st.initBusy = 1'b1;
			next_st.initCnt = 11'h000;
			next_st.gain = GAIN_FIX;
		end

		// pin controls, decoded from the next state so they line up with it
		next_st.out.mixerHiZ = !next_st.ctrl.spkPower;
		next_st.out.spkNegHiZ = !next_st.ctrl.spkPower;
		next_st.out.spkPosHiZ = !(next_st.ctrl.spkPower && next_st.ctrl.spkEn);
		next_st.out.spkNegMid = next_st.ctrl.spkPower && !next_st.ctrl.spkEn;
		next_st.out.ampOn = next_st.ctrl.spkPower && next_st.ctrl.spkEn;
		next_st.out.loEnable = next_st.lo == LO_ACTIVE;
		// an unpowered output with the save bit set already sits in power-save
		next_st.out.loSaveMode = (next_st.lo inside {LO_RAMPUP, LO_SAVE, LO_RAMPDN})
			|| (next_st.lo == LO_OFF && next_st.ctrl.loSave);
		next_st.out.loRampUp = next_st.lo == LO_RAMPUP;
		next_st.out.loRampDown = next_st.lo == LO_RAMPDN;
		next_st.out.loPulldown = next_st.lo == LO_OFF && !next_st.ctrl.loSave;
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			st <= stRst;
		end else begin
			st <= next_st;
		end
	end

	assign s_axi_awready = st.awRdy;
	assign s_axi_wready = st.wRdy;
	assign s_axi_bvalid = st.bValid;
	assign s_axi_bresp = st.bResp;
	assign s_axi_arready = st.arRdy;
	assign s_axi_rvalid = st.rValid;
	assign s_axi_rdata = st.rData;
	assign s_axi_rresp = st.rResp;
	assign speakerGainSel = st.ctrl.gainSel;
	assign levelGain = st.gain;
	assign pinCtrl = st.out;

	a_save_first: assert property (@(posedge core_clk) disable iff (rst)
		(st.lo == LO_ACTIVE && st.ctrl.loSave) |=> (st.lo == LO_SAVE && !pinCtrl.loEnable))
		else $error("save bit did not leave active line output");
	a_ramp_up_end: assert property (@(posedge core_clk) disable iff (rst)
		(st.lo == LO_RAMPUP && st.ctrl.loPower && st.rampCnt == RAMP_LEN - 22'h000001)
		|=> (st.lo == LO_SAVE && !pinCtrl.loRampUp))
		else $error("ramp up did not end on time");
	a_ramp_dn_end: assert property (@(posedge core_clk) disable iff (rst)
		(st.lo == LO_RAMPDN && !st.ctrl.loPower && st.rampCnt == RAMP_LEN - 22'h000001)
		|=> (st.lo == LO_OFF && pinCtrl.loSaveMode == st.ctrl.loSave))
		else $error("ramp down did not end on time");
	a_gain_select: assert property (@(posedge core_clk) disable iff (rst)
		$changed(speakerGainSel) |-> $past(st.bValid) == 1'b0 && st.bValid)
		else $error("gain select changed without a write");
	a_spk_off: assert property (@(posedge core_clk) disable iff (rst)
		!st.ctrl.spkPower |-> (pinCtrl.mixerHiZ && pinCtrl.spkPosHiZ && pinCtrl.spkNegHiZ))
		else $error("unpowered speaker pins not high impedance");
	a_spk_save: assert property (@(posedge core_clk) disable iff (rst)
		(st.ctrl.spkPower && !st.ctrl.spkEn)
		|-> (pinCtrl.spkPosHiZ && !pinCtrl.spkNegHiZ && pinCtrl.spkNegMid && !pinCtrl.ampOn))
		else $error("speaker power-save pins wrong");
	a_alc_off: assert property (@(posedge core_clk) disable iff (rst)
		(!st.ctrl.alcEn && !$past(st.ctrl.alcEn)) |-> levelGain == GAIN_FIX)
		else $error("disabled level control gain not fixed");
	a_limit_step: assert property (@(posedge core_clk) disable iff (rst)
		(run && levelGain != GAIN_FIX && $past(run) && levelGain < $past(levelGain))
		|-> (levelGain == $past(levelGain) - LIM_STEP && $past(st.limPhase) && $past(fsTick)))
		else $error("limiter step wrong");
	a_rec_ceiling: assert property (@(posedge core_clk) disable iff (rst)
		($past(run) && run && levelGain > $past(levelGain)) |-> (levelGain <= st.ceil
		&& levelGain - $past(levelGain) <= REC_STEP[5:0] && $past(st.recArmed)))
		else $error("recovery passed ceiling or step");
	a_hold_band: assert property (@(posedge core_clk) disable iff (rst)
		(run && !st.filt[SYN_ABOVE] && !st.filt[SYN_BELOW]) ##1 run |-> $stable(levelGain))
		else $error("gain moved inside hold band");
	a_init_start: assert property (@(posedge core_clk) disable iff (rst)
		$rose(st.ctrl.spkPower) |-> (st.initBusy && levelGain == GAIN_FIX) ##1 st.initBusy)
		else $error("initialization did not start");
	a_init_end: assert property (@(posedge core_clk) disable iff (rst)
		($fell(st.initBusy) && st.ctrl.spkPower && st.ctrl.alcEn) |-> levelGain == GAIN_START)
		else $error("level control did not start from start code");
	a_off_save: assert property (@(posedge core_clk) disable iff (rst)
		(st.lo == LO_OFF && st.ctrl.loSave)
		|-> (pinCtrl.loSaveMode && !pinCtrl.loPulldown && !pinCtrl.loEnable))
		else $error("save bit did not hold line output in power-save");
	a_ramp_up_go: assert property (@(posedge core_clk) disable iff (rst)
		(st.lo == LO_OFF && st.ctrl.loPower && st.ctrl.loSave)
		|=> (st.lo == LO_RAMPUP && pinCtrl.loRampUp && st.rampCnt == 22'h000000))
		else $error("ramp up did not start from power-save");
	a_ramp_dn_go: assert property (@(posedge core_clk) disable iff (rst)
		(st.lo == LO_SAVE && !st.ctrl.loPower)
		|=> (st.lo == LO_RAMPDN && pinCtrl.loRampDown && st.rampCnt == 22'h000000))
		else $error("ramp down did not start from power-save");
	a_gain_floor: assert property (@(posedge core_clk) disable iff (rst)
		($past(run) && run && $past(levelGain) == GAIN_MIN) |-> levelGain <= REC_STEP[5:0])
		else $error("level gain wrapped below its lowest code");
endmodule

// file: testbench/slc_level_source.sv
// far-side model: free-running sample clock, level detector and zero-crossing strobe
`timescale 1ns/100ps
module slc_level_source
	import slc_pkg::*;
#(
	parameter int FS_DIV = 8
) (
	input  wire logic       core_clk,
	input  wire logic [1:0] levelMode,
	output logic            fsClk,
	output logic            levelAbove,
	output logic            levelBelow,
	output logic            zeroCross
);
	int div = 0;
	int zc  = 0;

	// sample clock runs free, the level controller needs it whenever enabled
	always @(posedge core_clk) begin
		div <= (div + 1) % FS_DIV;
		if (div == FS_DIV - 1)
			zc <= (zc + 1) % 64;
	end

	assign fsClk      = (div >= FS_DIV / 2);
	// one whole sample period high, so the filtered edge is seen once
	assign zeroCross  = (zc == 0);
	assign levelAbove = (levelMode == 2'h1);
	assign levelBelow = (levelMode == 2'h2);
endmodule

// file: testbench/tb_top.sv
// self-checking bench for the speaker and line-output control block
`timescale 1ns/100ps
module tb_top
	import slc_pkg::*;
;
	localparam int RLEN = 20;
	localparam int FS   = 8;
	localparam logic [3:0] CT = OFS_CTRL;
	localparam logic [3:0] ST = OFS_STAT;
	localparam logic [1:0] OK = RESP_OKAY;

	logic        core_clk = 1'h0;
	logic        rst      = 1'h1;
	logic        awvalid  = 1'h0;
	logic        wvalid   = 1'h0;
	logic        bready   = 1'h0;
	logic        arvalid  = 1'h0;
	logic        rready   = 1'h0;
	logic [31:0] awaddr   = 32'h0;
	logic [31:0] wdata    = 32'h0;
	logic [31:0] araddr   = 32'h0;
	logic [3:0]  wstrb    = 4'h0;
	logic [1:0]  levelMode = 2'h0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp, gainSel;
	logic [31:0] rdata;
	logic        fsClk, levelAbove, levelBelow, zeroCross;
	logic [5:0]  levelGain;
	slc_out_type pinCtrl;
	int          err_total    = 0;
	int          total_checks = 0;
	int          cycles       = 0;
	int          n;

	slc_speaker_lineout_ctrl #(.RAMP_LEN(22'(RLEN))) i_slc_speaker_lineout_ctrl (
		.core_clk(core_clk), .rst(rst),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .fsClk(fsClk),
		.levelAbove(levelAbove), .levelBelow(levelBelow), .zeroCross(zeroCross),
		.speakerGainSel(gainSel), .levelGain(levelGain), .pinCtrl(pinCtrl)
	);

	slc_level_source #(.FS_DIV(FS)) i_slc_level_source (
		.core_clk(core_clk), .levelMode(levelMode), .fsClk(fsClk),
		.levelAbove(levelAbove), .levelBelow(levelBelow), .zeroCross(zeroCross)
	);

	always #50 core_clk = ~core_clk;

	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	always @(posedge core_clk) begin
		cycles++;
		if (cycles > 60000) begin
			err_total++;
			$display("BAD %0t run too long", $time);
			complete_run();
		end
	end

	task automatic ck(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge core_clk);
	endtask

	// write and compare the response code
	// no local limit: only the bench timeout ends a wait for the answer
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge core_clk);
		awvalid <= 1'h1;
		wvalid  <= 1'h1;
		awaddr  <= {28'h0, a};
		wdata   <= d;
		wstrb   <= 4'hf;
		bready  <= 1'h1;
		do begin
			@(posedge core_clk);
			if (awready)
				awvalid <= 1'h0;
			if (wready)
				wvalid <= 1'h0;
		end while ((awvalid && !awready) || (wvalid && !wready));
		while (bvalid !== 1'h1) begin
			@(posedge core_clk);
		end
		bready <= 1'h0;
		ck(bresp, er);
	endtask

	// read and compare the masked data and the response code
	task automatic rd(input logic [3:0] a, input logic [31:0] ex, input logic [31:0] m,
			input logic [1:0] er);
		@(posedge core_clk);
		arvalid <= 1'h1;
		araddr  <= {28'h0, a};
		rready  <= 1'h1;
		do begin
			@(posedge core_clk);
			if (arready)
				arvalid <= 1'h0;
		end while (rvalid !== 1'h1);
		rready <= 1'h0;
		ck(rdata & m, ex);
		ck(rresp, er);
	endtask

	task automatic gwait(input logic [5:0] g, input int lim, output int took);
		took = 0;
		while (levelGain !== g && took < lim) begin
			@(negedge core_clk);
			took++;
		end
	endtask

	initial begin
		tick(16);
		rst <= 1'h0;
		tick(2);
		ck(pinCtrl, 32'h381);
		rd(CT, 32'h0, 32'hff, OK);
		rd(OFS_CEIL, 32'h10, 32'h3f, OK);
		rd(ST, 32'h9, 32'h7f, OK);
		wr(4'hc, 32'h1, RESP_SLVERR);
		rd(4'hc, 32'h0, 32'hffffffff, RESP_SLVERR);
		wr(ST, 32'hff, OK);
		rd(ST, 32'h9, 32'h7f, OK);
		wr(OFS_CEIL, 32'h4, OK);
		rd(OFS_CEIL, 32'h4, 32'h3f, OK);
		// line output power-up and power-down with pop reduction
		wr(CT, 32'h2, OK);
		tick(2);
		ck(pinCtrl.loPulldown, 1'h0);
		ck(pinCtrl.loSaveMode, 1'h1);
		wr(CT, 32'h3, OK);
		tick(2);
		ck(pinCtrl.loRampUp, 1'h1);
		rd(ST, 32'h100, 32'h700, OK);
		tick(RLEN);
		rd(ST, 32'h200, 32'h700, OK);
		ck(pinCtrl.loSaveMode, 1'h1);
		wr(CT, 32'h1, OK);
		tick(2);
		ck(pinCtrl.loEnable, 1'h1);
		ck(pinCtrl.loSaveMode, 1'h0);
		rd(ST, 32'h300, 32'h700, OK);
		wr(CT, 32'h3, OK);
		tick(2);
		rd(ST, 32'h200, 32'h700, OK);
		wr(CT, 32'h2, OK);
		tick(2);
		ck(pinCtrl.loRampDown, 1'h1);
		rd(ST, 32'h400, 32'h700, OK);
		tick(RLEN);
		rd(ST, 32'h0, 32'h700, OK);
		wr(CT, 32'h0, OK);
		tick(2);
		ck(pinCtrl.loPulldown, 1'h1);
		ck(pinCtrl.loSaveMode, 1'h0);
		// speaker power-save, gain select, level control off
		wr(CT, 32'h4, OK);
		tick(2);
		ck(pinCtrl[9:6], 4'h5);
		rd(ST, 32'h49, 32'h7f, OK);
		tick(512 * FS + 300);
		rd(ST, 32'h9, 32'h7f, OK);
		for (int g = 0; g < 4; g++) begin
			wr(CT, {24'h0, 2'h0, g[1:0], 4'hc}, OK);
			tick(2);
			ck(gainSel, g[1:0]);
		end
		ck(pinCtrl.spkPosHiZ, 1'h0);
		ck(pinCtrl.ampOn, 1'h1);
		wr(CT, 32'h4, OK);
		wr(CT, 32'h0, OK);
		tick(2);
		ck(pinCtrl[9:7], 3'h7);
		// level control: initialization, limiter, hold, recovery
		wr(CT, 32'h44, OK);
		gwait(6'hc, 6000, n);
		ck(n > 512 * FS - 150 && n < 512 * FS + 150, 1'h1);
		wr(CT, 32'h4c, OK);
		@(posedge core_clk);
		levelMode <= 2'h1;
		gwait(6'hb, 200, n);
		gwait(6'ha, 200, n);
		ck(n, 2 * FS);
		gwait(6'h0, 400, n);
		tick(200);
		ck(levelGain, 6'h0);
		levelMode <= 2'h0;
		tick(5000);
		ck(levelGain, 6'h0);
		levelMode <= 2'h2;
		gwait(6'h2, 9000, n);
		ck(levelGain, 6'h2);
		ck(n > 512 * FS - 50, 1'h1);
		gwait(6'h4, 9000, n);
		ck(levelGain, 6'h4);
		tick(9000);
		ck(levelGain, 6'h4);
		wr(CT, 32'hc, OK);
		tick(2);
		ck(levelGain, 6'h9);
		// slow period select: set while unpowered, then the longer initialization
		wr(CT, 32'h80, OK);
		wr(CT, 32'hc4, OK);
		gwait(6'hc, 10000, n);
		ck(n > 1024 * FS - 150 && n < 1024 * FS + 150, 1'h1);
		complete_run();
	end
endmodule
